/* File: ipr_pkg.sv */
// package: register map, field layout and reset values of the priority block
//
// Overview of operation
// - each priority field is three bits; its binary value is its level.
// - a field holding 000 disables its source; never presented as pending.
// - user source priority fields except dac right come out of reset at level 4.
// - unimplemented bits read zero and ignore writes.
// - status bits 6..0 show pending vector minus eight, reset zero.
// - codec error priority at bits 14..12; bits 11..0 unimplemented.
// - crc error at 14..12, serial2 error 10..8, serial1 error 6..4.
// - can tx request at 10..8, dma ch7 at 6..4, dma ch6 at 2..0.
// - without the can controller, can sources stay disabled.
// - dac left at 14..12; dac right at 10..8, reset to 000.
// - without the audio dac, both dac sources stay disabled.
package ipr_pkg;

    // ========================================================================
    // register byte addresses
    localparam logic [7:0] ipr_codec_err_addr = 8'h00;
    localparam logic [7:0] ipr_rtc_dma5_addr = 8'h04;
    localparam logic [7:0] ipr_crc_serial_addr = 8'h08;
    localparam logic [7:0] ipr_can_dma67_addr = 8'h0c;
    localparam logic [7:0] ipr_dac_addr = 8'h10;
    localparam logic [7:0] ipr_status_addr = 8'h14;

    // ========================================================================
    // field positions (low bit of each three-bit field, then of the status level and vector fields)
    localparam int ipr_pos_hi = 12;
    localparam int ipr_pos_mid = 8;
    localparam int ipr_pos_lo = 4;
    localparam int ipr_pos_bot = 0;
    localparam int ipr_level_pos = 8;
    localparam int ipr_vector_pos = 0;

    // ========================================================================
    // reset values
    localparam logic [2:0] ipr_prio_reset = 3'h4;
    localparam logic [2:0] ipr_prio_off = 3'h0;
    localparam logic [3:0] ipr_level_reset = 4'h0;
    localparam logic [6:0] ipr_vector_reset = 7'h00;

    // axi response codes
    localparam logic [1:0] ipr_resp_okay = 2'h0;
    localparam logic [1:0] ipr_resp_slverr = 2'h2;

    // number of sources held here
    localparam int ipr_num_src = 12;

    // source indices into the priority vector
    typedef enum logic [3:0] {
        ipr_src_codec_err = 4'h0,
        ipr_src_rtc = 4'h1,
        ipr_src_dma5 = 4'h2,
        ipr_src_codec_evt = 4'h3,
        ipr_src_crc = 4'h4,
        ipr_src_ser2 = 4'h5,
        ipr_src_ser1 = 4'h6,
        ipr_src_can_tx = 4'h7,
        ipr_src_dma7 = 4'h8,
        ipr_src_dma6 = 4'h9,
        ipr_src_dac_l = 4'ha,
        ipr_src_dac_r = 4'hb
    } ipr_src_t;

    // arbitration result as it lands in the status register
    typedef struct packed {
        logic [3:0] level;
        logic [6:0] vector;
    } ipr_status_t;

endpackage : ipr_pkg

/* File: ipr_regs.sv */
// module: priority registers, status register and axi4-lite slave
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module ipr_regs #(
    parameter bit has_can = 1'b1,
    parameter bit has_dac = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // arbitration logic result, same clock
    input wire logic arb_update,
    input wire logic [3:0] arb_new_cpu_level,
    input wire logic [6:0] arb_pending_vector_code,
    // effective per-source priorities to the arbiter, 3 bits per source
    output logic [35:0] src_prio
);

    // ========================================================================
    // storage
    logic [2:0] prio [ipr_pkg::ipr_num_src];
    ipr_pkg::ipr_status_t status;

    // write channel capture
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    // ========================================================================
    // decode: does an address name a mapped register
    function automatic logic is_mapped(input logic [7:0] a);
        if (a == ipr_pkg::ipr_codec_err_addr)
            is_mapped = 1'b1;
        else if (a == ipr_pkg::ipr_rtc_dma5_addr)
            is_mapped = 1'b1;
        else if (a == ipr_pkg::ipr_crc_serial_addr)
            is_mapped = 1'b1;
        else if (a == ipr_pkg::ipr_can_dma67_addr)
            is_mapped = 1'b1;
        else if (a == ipr_pkg::ipr_dac_addr)
            is_mapped = 1'b1;
        else if (a == ipr_pkg::ipr_status_addr)
            is_mapped = 1'b1;
        else
            is_mapped = 1'b0;
    endfunction : is_mapped

    // read data for an address; unimplemented bits are zero
    function automatic logic [31:0] read_word(input logic [7:0] a);
        read_word = 32'h0000_0000;
        if (a == ipr_pkg::ipr_codec_err_addr)
        begin
            read_word[14:12] = prio[ipr_pkg::ipr_src_codec_err];
        end
        else if (a == ipr_pkg::ipr_rtc_dma5_addr)
        begin
            read_word[10:8] = prio[ipr_pkg::ipr_src_rtc];
            read_word[6:4] = prio[ipr_pkg::ipr_src_dma5];
            read_word[2:0] = prio[ipr_pkg::ipr_src_codec_evt];
        end
        else if (a == ipr_pkg::ipr_crc_serial_addr)
        begin
            read_word[14:12] = prio[ipr_pkg::ipr_src_crc];
            read_word[10:8] = prio[ipr_pkg::ipr_src_ser2];
            read_word[6:4] = prio[ipr_pkg::ipr_src_ser1];
        end
        else if (a == ipr_pkg::ipr_can_dma67_addr)
        begin
            read_word[10:8] = prio[ipr_pkg::ipr_src_can_tx];
            read_word[6:4] = prio[ipr_pkg::ipr_src_dma7];
            read_word[2:0] = prio[ipr_pkg::ipr_src_dma6];
        end
        else if (a == ipr_pkg::ipr_dac_addr)
        begin
            read_word[14:12] = prio[ipr_pkg::ipr_src_dac_l];
            read_word[10:8] = prio[ipr_pkg::ipr_src_dac_r];
        end
        else if (a == ipr_pkg::ipr_status_addr)
        begin
            read_word[11:8] = status.level;
            read_word[6:0] = status.vector;
        end
    endfunction : read_word

    // ========================================================================
    // write address / data acceptance; each held until the write is performed and its response raised
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
        else if (do_write)
        begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
        else if (do_write)
        begin
            w_held <= 1'b0;
        end
    end

    // ready is a flop: high while the channel slot is empty and no answer
    // waits, so nothing new is taken while bready holds a response back
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end
        else
        begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
                && !(s_axi_bvalid && !s_axi_bready);
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready)
                && !(s_axi_bvalid && !s_axi_bready);
        end
    end

    // write response; unmapped addresses answer slverr
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= ipr_pkg::ipr_resp_okay;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(aw_addr) ? ipr_pkg::ipr_resp_okay
                                              : ipr_pkg::ipr_resp_slverr;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ========================================================================
    // priority fields; only byte lanes 1 and 0 hold anything
    generate
        for (genvar i = 0; i < ipr_pkg::ipr_num_src; i++)
        begin : g_prio
            localparam logic [7:0] addr =
                (i == 0) ? ipr_pkg::ipr_codec_err_addr :
                (i <= 3) ? ipr_pkg::ipr_rtc_dma5_addr :
                (i <= 6) ? ipr_pkg::ipr_crc_serial_addr :
                (i <= 9) ? ipr_pkg::ipr_can_dma67_addr :
                ipr_pkg::ipr_dac_addr;
            localparam int pos =
                (i == 0 || i == 4 || i == 10) ? ipr_pkg::ipr_pos_hi :
                (i == 1 || i == 5 || i == 7 || i == 11) ? ipr_pkg::ipr_pos_mid :
                (i == 2 || i == 6 || i == 8) ? ipr_pkg::ipr_pos_lo :
                ipr_pkg::ipr_pos_bot;
            // dac right is the one source that wakes up disabled
            localparam logic [2:0] rst_val = (i == 11) ? ipr_pkg::ipr_prio_off
                                                       : ipr_pkg::ipr_prio_reset;
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                    prio[i] <= rst_val;
                else if (do_write && aw_addr == addr && w_strb[pos / 8])
                    prio[i] <= w_data[pos +: 3];
            end
        end
    endgenerate

    // ========================================================================
    // status register, loaded by arbitration only; bus writes never reach it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            status.level <= ipr_pkg::ipr_level_reset;
            status.vector <= ipr_pkg::ipr_vector_reset;
        end
        else if (arb_update)
        begin
            status.level <= arb_new_cpu_level;
            status.vector <= arb_pending_vector_code;
        end
    end

    // ========================================================================
    // read channel: one read at a time, data registered with the response
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ipr_pkg::ipr_resp_okay;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= read_word(s_axi_araddr);
            s_axi_rresp <= is_mapped(s_axi_araddr) ? ipr_pkg::ipr_resp_okay
                                                   : ipr_pkg::ipr_resp_slverr;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
        else
        begin
            s_axi_arready <= 1'b1;
        end
    end

    // ========================================================================
    // effective priorities to arbiter: 000 means disabled, absent units forced
    // off so the arbiter cannot present them whatever software wrote
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            src_prio <= 36'h0_0000_0000;
        else
            for (int i = 0; i < ipr_pkg::ipr_num_src; i++)
            begin
                if (i == ipr_pkg::ipr_src_can_tx && !has_can)
                    src_prio[3 * i +: 3] <= ipr_pkg::ipr_prio_off;
                else if ((i == ipr_pkg::ipr_src_dac_l ||
                          i == ipr_pkg::ipr_src_dac_r) && !has_dac)
                    src_prio[3 * i +: 3] <= ipr_pkg::ipr_prio_off;
                else
                    src_prio[3 * i +: 3] <= prio[i];
            end
    end

endmodule : ipr_regs

/* File: ipr_properties.sv */
// checker for the priority register block, bound to its ports
`timescale 1ns/1ps
module ipr_props #(
    parameter bit has_can = 1'b1,
    parameter bit has_dac = 1'b1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [35:0] src_prio
);
    // ========================================================
    // fields forced off on variants without the can or dac
    localparam logic [35:0] keep =
        ~{{6{!has_dac}}, 6'h0, {3{!has_can}}, 21'h0};
    localparam logic [35:0] rst = {3'h0, {11{3'h4}}};
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // ========================================================
    // read and write answers
    a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer missing");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_unused_zero: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7])
        else $error("unused bits not zero");
    a_unmapped_err: assert property (rd_taken ##0 s_axi_araddr > 8'h14
        |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_wr_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write answer missing");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write answer dropped");
    a_busy_refuse: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready)
        else $error("accepted while answer pending");
    // priorities: reset levels, dac right starts disabled
    a_reset_prio: assert property ($rose(aresetn)
        |=> src_prio == (rst & keep))
        else $error("reset priorities wrong");
    a_variant_off: assert property ((src_prio & ~keep) == 36'h0)
        else $error("absent source enabled");
endmodule : ipr_props

bind ipr_regs ipr_props #(.has_can(has_can), .has_dac(has_dac)) u_chk (.*);

/* File: ipr_arb_model.sv */
// arbitration-side model that loads results into the status register
`timescale 1ns/1ps
module ipr_arb_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic [3:0] dly,
    input wire ipr_pkg::ipr_status_t res,
    output logic arb_update,
    output ipr_pkg::ipr_status_t arb_data
);
    // ========================================================
    // wait dly cycles, then a one-cycle load of the result
    logic [3:0] cnt;
    always_ff @(posedge aclk)
    begin
        arb_update <= 1'b0;
        arb_data <= ~arb_data; // data toggles when not loading
        if (!aresetn)
        begin
            cnt <= 4'h0;
            arb_data <= 11'h2aa;
        end
        else if (req)
            cnt <= dly + 4'h1;
        else if (cnt == 4'h1)
        begin
            cnt <= 4'h0;
            arb_update <= 1'b1; // sole writer of status
            arb_data <= res;
        end
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
endmodule : ipr_arb_model

/* File: tb_top.sv */
// self-checking bench for the priority register block
`timescale 1ns/1ps
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, req = 1'b0;
    logic aw_v = 1'b0, w_v = 1'b0, b_r = 1'b0, ar_v = 1'b0, r_r = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf, dly = 4'h0;
    logic aw_r, w_r, b_v, ar_r, r_v, upd;
    logic [1:0] bresp, rresp;
    logic [35:0] prio, prio_nc, e;
    ipr_pkg::ipr_status_t res = '0, arb;
    logic [33:0] expq[$];
    logic [15:0] v[5];
    logic [15:0] rst_tab[6] = '{16'h4000, 16'h0444, 16'h4440, 16'h0444,
        16'h4000, 16'h0000};
    logic [15:0] msk[5] = '{16'h7000, 16'h0777, 16'h7770, 16'h0777,
        16'h7700};
    int n_fail = 0, num_checks = 0, cyc = 0;
    always #5 aclk = ~aclk;
    // ========================================================
    // full block plus a variant without can and dac
    ipr_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
        .s_axi_bresp(bresp), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(araddr), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(r_v),
        .s_axi_rready(r_r), .arb_update(upd), .arb_new_cpu_level(arb.level),
        .arb_pending_vector_code(arb.vector), .src_prio(prio));
    ipr_regs #(.has_can(1'b0), .has_dac(1'b0)) DUT_nc (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(aw_v),
        .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(w_v), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(b_r), .s_axi_araddr(araddr),
        .s_axi_arvalid(ar_v), .s_axi_arready(), .s_axi_rdata(),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(r_r),
        .arb_update(upd), .arb_new_cpu_level(arb.level),
        .arb_pending_vector_code(arb.vector), .src_prio(prio_nc));
    ipr_arb_model u_arb (.aclk(aclk), .aresetn(aresetn), .req(req),
        .dly(dly), .res(res), .arb_update(upd), .arb_data(arb));
    // ========================================================
    // comparison, bus tasks, verdict
    task automatic chk(input string nm, input logic [35:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [1:0] rsp);
        expq.push_back({rsp, 32'h0});
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        aw_v <= 1'b1;
        w_v <= 1'b1;
        b_r <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (aw_r) aw_v <= 1'b0;
            if (w_r) w_v <= 1'b0;
        end while (!b_v);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] x);
        expq.push_back(x);
        araddr <= a;
        ar_v <= 1'b1;
        r_r <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (ar_r) ar_v <= 1'b0;
        end while (!r_v);
    endtask : rd
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // answers are matched in order against the noted results
    logic [33:0] ans;
    assign ans = b_v ? {bresp, 32'h0} : {rresp, rdata};
    always @(posedge aclk)
        if ((b_v && b_r) || (r_v && r_r))
            chk("answer", 36'(ans), 36'(expq.pop_front()));
    // hang guard, far above the roughly 150 cycles needed
    always @(posedge aclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            complete_run();
        end
    end
    initial
    begin
        void'($urandom(32'h07d0b79f));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk("prio", prio, {3'h0, {11{3'h4}}});
        chk("prio_nc", prio_nc, {6'h0, {2{3'h4}}, 3'h0, {7{3'h4}}});
        for (int i = 0; i < 6; i++)
            rd(8'(i * 4), {18'h0, rst_tab[i]});
        // random levels, unused bits written as ones
        for (int i = 0; i < 5; i++)
        begin
            v[i] = 16'($urandom()) & msk[i];
            wr(8'(i * 4), {16'hffff, v[i] | ~msk[i]}, 4'hf, 2'h0);
        end
        for (int i = 0; i < 5; i++)
            rd(8'(i * 4), {18'h0, v[i]});
        e = {v[4][10:8], v[4][14:12], v[3][2:0], v[3][6:4], v[3][10:8],
            v[2][6:4], v[2][10:8], v[2][14:12], v[1][2:0], v[1][6:4],
            v[1][10:8], v[0][14:12]};
        chk("prio", prio, e);
        chk("prio_nc", prio_nc, e & ~36'hfc0e00000);
        wr(8'h08, 32'h0, 4'h1, 2'h0);
        rd(8'h08, {18'h0, v[2] & 16'h7700});
        // every level code, 000 last seen as disabled
        for (int j = 7; j >= 0; j--)
        begin
            wr(8'h00, {17'h0, 3'(j), 12'hfff}, 4'hf, 2'h0);
            repeat (2) @(posedge aclk);
            chk("level", 36'(prio[2:0]), 36'(j));
        end
        wr(8'h14, 32'hffffffff, 4'hf, 2'h0);
        rd(8'h14, 34'h0);
        for (int k = 0; k < 3; k++)
        begin
            res <= (k == 0) ? 11'h7ff : (k == 1) ? 11'h0 : 11'($urandom());
            dly <= 4'(k * 5);
            req <= 1'b1;
            @(posedge aclk);
            req <= 1'b0;
            do @(posedge aclk); while (!upd);
            rd(8'h14, {22'h0, res.level, 1'b0, res.vector});
        end
        rd(8'h18, {2'h2, 32'h0});
        wr(8'h20, 32'hffffffff, 4'hf, 2'h2);
        // let the monitor compare the last answer before the verdict
        @(posedge aclk);
        complete_run();
    end
endmodule : tb_top
